// ---- design/rcrm_map.svh ----
// Operation
// - the relative call carries an 11-bit signed word offset from -1024 to 1023.
// - the relative call first pushes the address of the next instruction, counter plus 2, onto the stack top.
// - the relative call target is counter plus 2 plus twice the signed offset.
// - the relative call takes two instruction cycles, the second a no-operation while the target is fetched.
// - the software reset opcode (low byte all ones) returns the execute state, but not the quarter phase, to master-clear values from the fourth quarter.
// - both multiplies write the product pair in the fourth quarter of their single cycle.
// - the multiply is unsigned 8x8 to 16 bits, high byte to the high register, accumulator and flags untouched.
// - every instruction cycle is four oscillator periods, quarters one to four, and sequencing runs on them.
`ifndef RCRM_MAP_SVH
`define RCRM_MAP_SVH
`define RCRM_PC_W        21
`define RCRM_OFS_W       11
`define RCRM_QUARTERS    4
`define RCRM_PC_STEP     21'h000002
`define RCRM_CALL_PFX    5'h1b
`define RCRM_RESET_OP    16'h00ff
`define RCRM_MULLIT_PFX  8'h0d
`define RCRM_MULREG_PFX  7'h01
`define RCRM_PROD_RST    8'h00
`endif

// ---- design/rcrm_pkg.sv ----
package rcrm_pkg;
  typedef enum logic [1:0] {QONE, QTWO, QTHREE, QFOUR} rcrm_quarter_e;
  typedef enum logic [1:0] {EX_IDLE, EX_CALL, EX_MUL, EX_RST} rcrm_kind_e;
endpackage

// ---- design/rcrm_quarter_gen.sv ----
`timescale 1ns/1ps
module rcrm_quarter_gen
  import rcrm_pkg::*;
(
  // clock and reset
  input  wire logic          clk,
  input  wire logic          srst,
  // quarter phase
  output rcrm_quarter_e      quarter,
  output logic               cycleStart
);
  typedef struct packed {
    rcrm_quarter_e q;
  } rcrm_qg_s;
  rcrm_qg_s st_q, st_d;

  always_comb begin
    st_d = st_q;
    unique case (st_q.q)
      QONE:   st_d.q = QTWO;
      QTWO:   st_d.q = QTHREE;
      QTHREE: st_d.q = QFOUR;
      QFOUR:  st_d.q = QONE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q.q <= QONE;
    end else begin
      st_q <= st_d;
    end
  end

  assign quarter    = st_q.q;
  assign cycleStart = (st_q.q == QONE);
endmodule

// ---- design/rcrm_exec.sv ----
`timescale 1ns/1ps
`include "rcrm_map.svh"
module rcrm_exec
  import rcrm_pkg::*;
(
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    srst,
  // instruction in, sampled at quarter one
  input  wire logic [15:0]             instrWord,
  input  wire logic                    instrValid,
  input  wire logic [`RCRM_PC_W-1:0]   pcIn,
  // multiply operands
  input  wire logic [7:0]              accumIn,
  input  wire logic [7:0]              fileIn,
  // quarter phase
  output rcrm_quarter_e                quarter,
  output logic                         cycleStart,
  // stack push
  output logic                         stackPush,
  output logic [`RCRM_PC_W-1:0]        stackTopEntry,
  // program counter load
  output logic                         pcLoad,
  output logic [`RCRM_PC_W-1:0]        pcTarget,
  output logic                         fetchNop,
  // product registers
  output logic [7:0]                   productHighByte,
  output logic [7:0]                   productLowByte,
  output logic                         productWrite,
  // software reset request to the core
  output logic                         softReset
);
  typedef struct packed {
    rcrm_kind_e                kind;
    logic                      secondCyc;
    logic [`RCRM_OFS_W-1:0]    ofs;
    logic [7:0]                mulB;
    logic [7:0]                product_high_byte;
    logic [7:0]                product_low_byte;
    logic [`RCRM_PC_W-1:0]     pushAddr;
    logic [`RCRM_PC_W-1:0]     tgt;
    logic                      push;
    logic                      load;
    logic                      pwr;
    logic                      rst;
  } rcrm_ex_s;
  rcrm_ex_s st_q, st_d;

  function automatic logic [`RCRM_PC_W-1:0] callTarget(
    input logic [`RCRM_PC_W-1:0] pc,
    input logic [`RCRM_OFS_W-1:0] n);
    logic [`RCRM_PC_W-1:0] sx;
    sx = {{(`RCRM_PC_W-`RCRM_OFS_W){n[`RCRM_OFS_W-1]}}, n};
    callTarget = pc + `RCRM_PC_STEP + {sx[`RCRM_PC_W-2:0], 1'b0};
  endfunction

  rcrm_quarter_gen uQuarter (
    .clk        (clk),
    .srst       (srst),
    .quarter    (quarter),
    .cycleStart (cycleStart)
  );

  logic [15:0] prod;
  assign prod = st_q.mulB * accumIn;

  always_comb begin
    st_d      = st_q;
    st_d.push = 1'b0;
    st_d.load = 1'b0;
    st_d.pwr  = 1'b0;
    unique case (quarter)
      QONE: begin
        st_d.rst = 1'b0;
        if (st_q.kind == EX_CALL && !st_q.secondCyc) begin
          st_d.secondCyc = 1'b1;
        end else begin
          st_d.kind      = EX_IDLE;
          st_d.secondCyc = 1'b0;
          if (instrValid) begin
            if (instrWord[15:11] == `RCRM_CALL_PFX) begin
              st_d.kind = EX_CALL;
              st_d.ofs  = instrWord[`RCRM_OFS_W-1:0];
              st_d.pushAddr = pcIn + `RCRM_PC_STEP;
              st_d.tgt  = callTarget(pcIn, instrWord[`RCRM_OFS_W-1:0]);
            end else if (instrWord == `RCRM_RESET_OP) begin
              st_d.kind = EX_RST;
            end else if (instrWord[15:8] == `RCRM_MULLIT_PFX) begin
              st_d.kind = EX_MUL;
              st_d.mulB = instrWord[7:0];
            end else if (instrWord[15:9] == `RCRM_MULREG_PFX) begin
              st_d.kind = EX_MUL;
              st_d.mulB = fileIn;
            end
          end
        end
      end
      QTWO: begin
        // reset is raised here, the rest of the cycle is idle
        if (st_q.kind == EX_RST) begin
          st_d.rst = 1'b1;
        end
        // push before the counter moves, so the stack sees the old flow
        if (st_q.kind == EX_CALL && !st_q.secondCyc) begin
          st_d.push = 1'b1;
        end
      end
      QTHREE: begin
        if (st_q.kind == EX_CALL && !st_q.secondCyc) begin
          st_d.load = 1'b1;
        end
      end
      QFOUR: begin
        if (st_q.kind == EX_MUL) begin
          st_d.product_high_byte = prod[15:8];
          st_d.product_low_byte = prod[7:0];
          st_d.pwr   = 1'b1;
        end
        if (st_q.kind == EX_RST) begin
          st_d.kind = EX_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst || st_q.rst) begin
      st_q.kind      <= EX_IDLE;
      st_q.secondCyc <= 1'b0;
      st_q.ofs       <= '0;
      st_q.mulB      <= 8'h00;
      st_q.product_high_byte     <= `RCRM_PROD_RST;
      st_q.product_low_byte     <= `RCRM_PROD_RST;
      st_q.pushAddr  <= '0;
      st_q.tgt       <= '0;
      st_q.push      <= 1'b0;
      st_q.load      <= 1'b0;
      st_q.pwr       <= 1'b0;
      // the request drops after one clock, the rest of the cycle idles
      st_q.rst       <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  assign stackPush       = st_q.push;
  assign stackTopEntry   = st_q.pushAddr;
  assign pcLoad          = st_q.load;
  assign pcTarget        = st_q.tgt;
  assign fetchNop        = st_q.secondCyc;
  assign productHighByte = st_q.product_high_byte;
  assign productLowByte  = st_q.product_low_byte;
  assign productWrite    = st_q.pwr;
  assign softReset       = st_q.rst;
endmodule

// ---- dv/rcrm_exec_sva.sv ----
`timescale 1ns/1ps
`include "rcrm_map.svh"
module rcrm_exec_sva
  import rcrm_pkg::*;
(
  // clock, reset, inputs
  input wire logic                  clk,
  input wire logic                  srst,
  input wire logic [15:0]           instrWord,
  input wire logic                  instrValid,
  input wire logic [`RCRM_PC_W-1:0] pcIn,
  // outputs
  input rcrm_quarter_e              quarter,
  input wire logic                  cycleStart,
  input wire logic                  stackPush,
  input wire logic [`RCRM_PC_W-1:0] stackTopEntry,
  input wire logic                  pcLoad,
  input wire logic                  fetchNop,
  input wire logic                  productWrite,
  input wire logic                  softReset
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // a call's second cycle refuses new work
  // the edge after a call's load opens its no-operation cycle
  logic loadSeen;
  always_ff @(posedge clk) begin
    if (srst) begin
      loadSeen <= 1'b0;
    end else begin
      loadSeen <= pcLoad;
    end
  end
  wire take = quarter == QONE && instrValid && !loadSeen;
  wire call = take && instrWord[15:11] == 5'h1b;
  wire mul = take && (instrWord[15:8] == 8'h0d || instrWord[15:9] == 7'h01);
  wire rst = take && instrWord == 16'h00ff;
  quarter_wrap_a: assert property (quarter == QFOUR |=> quarter == QONE)
    else $error("quarter did not wrap");
  start_flag_a: assert property (cycleStart == (quarter == QONE))
    else $error("cycle start wrong");
  push_time_a: assert property (call |-> ##2 stackPush
    && stackTopEntry == $past(pcIn, 2) + 21'h2) else $error("bad push");
  load_time_a: assert property (call |-> ##3 pcLoad ##2 fetchNop[*4])
    else $error("bad call timing");
  push_pulse_a: assert property (stackPush |=> !stackPush)
    else $error("push too long");
  mul_time_a: assert property (mul |-> ##4 productWrite)
    else $error("no product write");
  rst_time_a: assert property (rst |-> ##2 softReset ##1 !softReset)
    else $error("bad reset pulse");
  nop_refuse_a: assert property (loadSeen && quarter == QONE && instrValid
    |-> ##2 !softReset && !stackPush) else $error("refusal broken");
  cover property (call);
  cover property (mul);
  cover property (rst);
endmodule

// ---- dv/rcrm_exec_bench.sv ----
`timescale 1ns/1ps
module rcrm_exec_bench import rcrm_pkg::*;;
  logic          clk = 1'b0, srst = 1'b1, instrValid = 1'b0;
  logic [15:0]   instrWord = 16'h0000;
  logic [20:0]   pcIn = 21'h000000, stackTopEntry, pcTarget;
  logic [7:0]    accumIn = 8'h00, fileIn = 8'h00;
  logic [7:0]    productHighByte, productLowByte;
  logic          cycleStart, stackPush, pcLoad, fetchNop;
  logic          productWrite, softReset;
  rcrm_quarter_e quarter;
  int            fail_count = 0, num_checks = 0, cycles = 0;
  rcrm_exec dut (.*);
  always #4 clk = ~clk;
  task finish_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ceiling far above the few dozen cycles the run needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      fail_count++;
      finish_test;
    end
  end
  task chk(input string what, input logic [20:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask
  task skip(input int n);
    repeat (n) @(negedge clk);
  endtask
  // present at the edge that closes quarter four, taken one edge later
  task issue(input logic [15:0] w, input logic [20:0] pc);
    do @(negedge clk); while (quarter !== QFOUR);
    @(posedge clk);
    instrWord <= w;
    pcIn <= pc;
    instrValid <= 1'b1;
    @(posedge clk);
  endtask
  task do_mul(input logic [15:0] w, input logic [7:0] a, f);
    @(posedge clk);
    accumIn <= a;
    fileIn <= f;
    issue(w, 21'h0);
    instrValid <= 1'b0;
    skip(4);
    chk("pwrite", 1, productWrite);
    chk("product", a * f, {productHighByte, productLowByte});
  endtask
  task do_call(input logic [20:0] pc, input logic [10:0] n);
    issue({5'h1b, n}, pc);
    instrWord <= 16'h00ff;
    skip(2);
    chk("push", 1, stackPush);
    chk("stack", pc + 21'h2, stackTopEntry);
    chk("target", pc + 21'h2 + {{9{n[10]}}, n, 1'b0}, pcTarget);
    skip(1);
    chk("load", 1, pcLoad);
    skip(1);
    @(posedge clk) instrValid <= 1'b0;
    skip(2);
    chk("nop", 1, fetchNop);
    chk("refused", 0, softReset);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    do_mul(16'h0dc4, 8'he2, 8'hc4);
    do_mul(16'h0210, 8'hc4, 8'hb5);
    do_mul(16'h0dff, 8'hff, 8'hff);
    do_call(21'h001000, 11'h400);
    do_call(21'h000100, 11'h3ff);
    issue(16'h00ff, 21'h0);
    instrValid <= 1'b0;
    skip(2);
    chk("sreset", 1, softReset);
    skip(1);
    chk("sreset end", 0, softReset);
    chk("cleared", 0, {productHighByte, productLowByte});
    finish_test;
  end
endmodule
bind rcrm_exec rcrm_exec_sva chk (.*);
